// ==== hdl/tcs_pkg.sv ====
// Purpose: shared constants and types of the thermometer command link
// Assumes: 100 MHz ref_clk, link clock period 160 ns
// Notes: open-drain lines; enables are high while a party pulls low
package tcs_pkg;
  typedef logic [7:0] tcs_byte_t;
  // fixed upper bits of the 7-bit slave address
  localparam logic [3:0] TCS_ADDR_FIXED = 4'h9;
  localparam logic TCS_RW_WRITE = 1'b0;
  localparam logic TCS_RW_READ = 1'b1;
  localparam tcs_byte_t TCS_CMD_START_CONV = 8'h51;
  localparam tcs_byte_t TCS_CMD_STOP_CONV = 8'h22;
  localparam tcs_byte_t TCS_CMD_READ_TEMP = 8'hAA;
  localparam tcs_byte_t TCS_CMD_UPPER = 8'hA1;
  localparam tcs_byte_t TCS_CMD_LOWER = 8'hA2;
  localparam tcs_byte_t TCS_CMD_CONFIG = 8'hAC;
  localparam tcs_byte_t TCS_CMD_SOFT_POR = 8'h54;
  localparam int TCS_CFG_ONESHOT_BIT = 0;
  localparam int TCS_CFG_POL_BIT = 1;
  localparam tcs_byte_t TCS_CFG_RESET = 8'h00;
  localparam logic [15:0] TCS_THRESH_RESET = 16'h0000;
  localparam tcs_byte_t TCS_IDLE_BYTE = 8'hFF;
  localparam logic [3:0] TCS_BYTE_BITS = 4'h8;
  localparam int TCS_REF_CLK_NS = 10;
  localparam int TCS_SCL_PERIOD_NS = 160;
  localparam int TCS_SCL_QUARTER = TCS_SCL_PERIOD_NS / (4 * TCS_REF_CLK_NS);
  typedef enum logic [2:0] {
    TCS_D_IDLE = 3'b000,
    TCS_D_ADDR = 3'b001,
    TCS_D_ACK = 3'b010,
    TCS_D_CMD = 3'b011,
    TCS_D_DATA = 3'b100,
    TCS_D_TX = 3'b101,
    TCS_D_MACK = 3'b110
  } tcs_dev_state_t;
  typedef enum logic [1:0] {
    TCS_M_IDLE = 2'b00,
    TCS_M_START = 2'b01,
    TCS_M_BYTE = 2'b10,
    TCS_M_STOP = 2'b11
  } tcs_mst_state_t;
  typedef enum logic [2:0] {
    TCS_P_CTRL_W = 3'b000,
    TCS_P_CMD = 3'b001,
    TCS_P_WDATA = 3'b010,
    TCS_P_CTRL_R = 3'b011,
    TCS_P_RDATA = 3'b100
  } tcs_step_t;
endpackage

// ==== hdl/tcs_if.sv ====
// Purpose: two-wire link between the bus master and the thermometer
// Assumes: both lines pulled up; a driver only ever pulls low
// Notes: line levels are resolved here from the enables
interface tcs_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;
  assign scl = !(scl_oe_m && !scl_o_m);
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));
  modport master (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m,
                  input scl, input sda);
  modport device (output sda_o_s, output sda_oe_s, input scl, input sda);
endinterface

// ==== hdl/tcs_master.sv ====
// Purpose: bus master end: one START-to-STOP transaction per request
// Assumes: link clock made here from ref_clk by a quarter-period divider
// Notes: reads use a repeated START after the command byte
module tcs_master #(
  parameter int QUARTER = tcs_pkg::TCS_SCL_QUARTER
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  tcs_if.master bus,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [2:0] req_addr_sel,
  input wire tcs_pkg::tcs_byte_t req_cmd,
  input wire logic [1:0] req_count,
  input wire logic [15:0] req_wdata,
  output logic req_ready_q,
  output logic done_q,
  output logic nack_q,
  output logic [15:0] rdata_q
);
  import tcs_pkg::*;

  if (QUARTER < 4) begin : g_bad_quarter
    $error("QUARTER must be at least 4 ref_clk cycles");
  end

  tcs_mst_state_t state_q;
  tcs_step_t step_q;
  logic [15:0] div_q;
  logic tick;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic [8:0] rx_q;
  logic [8:0] load9;
  logic [8:0] cur9;
  logic [1:0] left_q;
  logic [1:0] count_q;
  logic rd_q;
  logic [2:0] sel_q;
  tcs_byte_t cmd_q;
  logic [15:0] wdata_q;
  logic sda_m1_q;
  logic sda_m2_q;

  assign tick = (div_q == 16'(QUARTER - 1));
  assign cur9 = (bit_q == 4'h0) ? load9 : sh_q;

  // ninth slot: 1 releases for the slave ack on writes; on reads 0 = ack, 1 = nack
  always_comb
  begin
    case (step_q)
      TCS_P_CTRL_W: load9 = {TCS_ADDR_FIXED, sel_q, TCS_RW_WRITE, 1'b1};
      TCS_P_CMD: load9 = {cmd_q, 1'b1};
      TCS_P_WDATA: load9 = {(left_q == count_q) ? wdata_q[15:8] : wdata_q[7:0], 1'b1};
      TCS_P_CTRL_R: load9 = {TCS_ADDR_FIXED, sel_q, TCS_RW_READ, 1'b1};
      TCS_P_RDATA: load9 = {TCS_IDLE_BYTE, left_q == 2'h1};
      default: load9 = {TCS_IDLE_BYTE, 1'b1};
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sda_m1_q <= 1'b1;
      sda_m2_q <= 1'b1;
    end
    else
    begin
      sda_m1_q <= bus.sda;
      sda_m2_q <= sda_m1_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || state_q == TCS_M_IDLE || tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_q <= TCS_M_IDLE;
      step_q <= TCS_P_CTRL_W;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 9'h1FF;
      rx_q <= 9'h000;
      left_q <= 2'h0;
      count_q <= 2'h0;
      rd_q <= 1'b0;
      sel_q <= 3'h0;
      cmd_q <= 8'h00;
      wdata_q <= 16'h0000;
      bus.scl_o_m <= 1'b0;
      bus.sda_o_m <= 1'b0;
      bus.scl_oe_m <= 1'b0;
      bus.sda_oe_m <= 1'b0;
      req_ready_q <= 1'b1;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      done_q <= 1'b0;
      if (state_q == TCS_M_IDLE)
      begin
        if (req_valid)
        begin
          state_q <= TCS_M_START;
          step_q <= TCS_P_CTRL_W;
          ph_q <= 2'h0;
          bit_q <= 4'h0;
          rd_q <= req_read;
          sel_q <= req_addr_sel;
          cmd_q <= req_cmd;
          wdata_q <= req_wdata;
          count_q <= req_count;
          left_q <= req_count;
          nack_q <= 1'b0;
          req_ready_q <= 1'b0;
        end
      end
      else if (tick)
      begin
        ph_q <= ph_q + 2'h1;
        case (state_q)
          TCS_M_START:
          begin
            // start condition: data falls while the clock is high
            case (ph_q)
              2'h0:
              begin
                bus.scl_oe_m <= 1'b1;
                bus.sda_oe_m <= 1'b0;
              end
              2'h1: bus.scl_oe_m <= 1'b0;
              2'h2: bus.sda_oe_m <= 1'b1;
              default:
              begin
                bus.scl_oe_m <= 1'b1;
                state_q <= TCS_M_BYTE;
              end
            endcase
          end
          TCS_M_BYTE:
          begin
            case (ph_q)
              2'h0:
              begin
                bus.sda_oe_m <= !cur9[8];
                sh_q <= {cur9[7:0], 1'b0};
              end
              2'h1: bus.scl_oe_m <= 1'b0;
              2'h2: rx_q <= {rx_q[7:0], sda_m2_q};
              default:
              begin
                bus.scl_oe_m <= 1'b1;
                bit_q <= bit_q + 4'h1;
                if (bit_q == TCS_BYTE_BITS)
                begin
                  bit_q <= 4'h0;
                  if (step_q != TCS_P_RDATA && rx_q[0])
                  begin
                    nack_q <= 1'b1;
                    state_q <= TCS_M_STOP;
                  end
                  else
                  begin
                    case (step_q)
                      TCS_P_CTRL_W: step_q <= TCS_P_CMD;
                      TCS_P_CMD:
                      begin
                        if (rd_q && left_q != 2'h0)
                        begin
                          step_q <= TCS_P_CTRL_R;
                          state_q <= TCS_M_START;
                        end
                        else if (left_q == 2'h0)
                          state_q <= TCS_M_STOP;
                        else
                          step_q <= TCS_P_WDATA;
                      end
                      TCS_P_CTRL_R: step_q <= TCS_P_RDATA;
                      TCS_P_RDATA:
                      begin
                        if (left_q == count_q)
                          rdata_q[15:8] <= rx_q[8:1];
                        else
                          rdata_q[7:0] <= rx_q[8:1];
                        left_q <= left_q - 2'h1;
                        if (left_q == 2'h1)
                          state_q <= TCS_M_STOP;
                      end
                      default:
                      begin
                        left_q <= left_q - 2'h1;
                        if (left_q == 2'h1)
                          state_q <= TCS_M_STOP;
                      end
                    endcase
                  end
                end
              end
            endcase
          end
          TCS_M_STOP:
          begin
            // stop condition: data rises while the clock is high
            case (ph_q)
              2'h0: bus.sda_oe_m <= 1'b1;
              2'h1: bus.scl_oe_m <= 1'b0;
              2'h2: bus.sda_oe_m <= 1'b0;
              default:
              begin
                state_q <= TCS_M_IDLE;
                done_q <= 1'b1;
                req_ready_q <= 1'b1;
              end
            endcase
          end
          default: state_q <= TCS_M_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== hdl/tcs_device.sv ====
// Purpose: thermometer end: two-wire slave holding config and trip thresholds
// Assumes: link lines and address straps are asynchronous to ref_clk
// Notes: conversion itself is outside; conv_start_q and conv_done hand off
module tcs_device (
  input wire logic ref_clk,
  input wire logic reset_n,
  tcs_if.device bus,
  input wire logic addr_select_hi,
  input wire logic addr_select_mid,
  input wire logic addr_select_lo,
  input wire logic [15:0] temperature_in,
  input wire logic conv_done,
  output tcs_pkg::tcs_byte_t config_q,
  output logic [15:0] upper_trip_threshold_q,
  output logic [15:0] lower_trip_threshold_q,
  output logic converting_q,
  output logic conv_start_q
);
  import tcs_pkg::*;

  logic [4:0] raw;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic rise;
  logic fall;
  tcs_dev_state_t state_q;
  logic [3:0] cnt_q;
  tcs_byte_t shift_q;
  tcs_byte_t tx_q;
  tcs_byte_t cmd_q;
  tcs_byte_t rd_byte;
  logic [1:0] idx_q;
  logic rw_q;
  logic got_cmd_q;
  logic mack_q;
  logic addr_hit;
  logic cmd_take;
  logic data_take;
  logic soft_por;
  logic single_conversion_select;

  assign raw = {addr_select_lo, addr_select_mid, addr_select_hi, bus.sda, bus.scl};

  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge ref_clk)
    begin
      if (!reset_n)
      begin
        sync1_q[i] <= 1'b1;
        sync2_q[i] <= 1'b1;
      end
      else
      begin
        sync1_q[i] <= raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  assign scl_s = sync2_q[0];
  assign sda_s = sync2_q[1];

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  assign rise = scl_s && !scl_prev_q;
  assign fall = !scl_s && scl_prev_q;

  // own address: fixed upper bits, then the three select pins
  assign addr_hit = (shift_q[7:1] == {TCS_ADDR_FIXED, sync2_q[2], sync2_q[3], sync2_q[4]});
  assign cmd_take = fall && state_q == TCS_D_CMD && cnt_q == TCS_BYTE_BITS;
  assign data_take = fall && state_q == TCS_D_DATA && cnt_q == TCS_BYTE_BITS;
  assign soft_por = cmd_take && shift_q == TCS_CMD_SOFT_POR;
  assign single_conversion_select = config_q[TCS_CFG_ONESHOT_BIT];

  always_comb
  begin
    case (cmd_q)
      TCS_CMD_CONFIG: rd_byte = config_q;
      TCS_CMD_UPPER: rd_byte = (idx_q == 2'h0) ? upper_trip_threshold_q[15:8]
                                               : upper_trip_threshold_q[7:0];
      TCS_CMD_LOWER: rd_byte = (idx_q == 2'h0) ? lower_trip_threshold_q[15:8]
                                               : lower_trip_threshold_q[7:0];
      TCS_CMD_READ_TEMP: rd_byte = (idx_q == 2'h0) ? temperature_in[15:8]
                                                   : temperature_in[7:0];
      default: rd_byte = TCS_IDLE_BYTE;
    endcase
  end

  // bus protocol engine
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_q <= TCS_D_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      got_cmd_q <= 1'b0;
      mack_q <= 1'b1;
      bus.sda_o_s <= 1'b0;
      bus.sda_oe_s <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= TCS_D_ADDR;
      cnt_q <= 4'h0;
      got_cmd_q <= 1'b0;
      bus.sda_oe_s <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= TCS_D_IDLE;
      bus.sda_oe_s <= 1'b0;
    end
    else if (rise)
    begin
      case (state_q)
        TCS_D_ADDR, TCS_D_CMD, TCS_D_DATA:
        begin
          shift_q <= {shift_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end
        TCS_D_MACK: mack_q <= sda_s;
        default: ;
      endcase
    end
    else if (fall)
    begin
      case (state_q)
        TCS_D_ADDR:
        begin
          if (cnt_q == TCS_BYTE_BITS)
          begin
            if (addr_hit)
            begin
              bus.sda_oe_s <= 1'b1;
              rw_q <= shift_q[0];
              state_q <= TCS_D_ACK;
            end
            else
              state_q <= TCS_D_IDLE;
          end
        end
        TCS_D_CMD:
        begin
          if (cnt_q == TCS_BYTE_BITS)
          begin
            bus.sda_oe_s <= 1'b1;
            cmd_q <= shift_q;
            got_cmd_q <= 1'b1;
            idx_q <= 2'h0;
            state_q <= TCS_D_ACK;
          end
        end
        TCS_D_DATA:
        begin
          if (cnt_q == TCS_BYTE_BITS)
          begin
            bus.sda_oe_s <= 1'b1;
            if (idx_q != 2'h3)
              idx_q <= idx_q + 2'h1;
            state_q <= TCS_D_ACK;
          end
        end
        TCS_D_ACK, TCS_D_MACK:
        begin
          cnt_q <= 4'h0;
          if (state_q == TCS_D_MACK && mack_q)
            state_q <= TCS_D_IDLE;
          else if (rw_q)
          begin
            tx_q <= {rd_byte[6:0], 1'b0};
            bus.sda_oe_s <= !rd_byte[7];
            cnt_q <= 4'h1;
            state_q <= TCS_D_TX;
          end
          else
          begin
            bus.sda_oe_s <= 1'b0;
            state_q <= got_cmd_q ? TCS_D_DATA : TCS_D_CMD;
          end
        end
        TCS_D_TX:
        begin
          if (cnt_q == TCS_BYTE_BITS)
          begin
            bus.sda_oe_s <= 1'b0;
            if (idx_q != 2'h3)
              idx_q <= idx_q + 2'h1;
            state_q <= TCS_D_MACK;
          end
          else
          begin
            bus.sda_oe_s <= !tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: ;
      endcase
    end
  end

  // stored settings; bytes beyond the register width are acked and dropped
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || soft_por)
    begin
      config_q <= TCS_CFG_RESET;
      upper_trip_threshold_q <= TCS_THRESH_RESET;
      lower_trip_threshold_q <= TCS_THRESH_RESET;
    end
    else if (data_take)
    begin
      case (cmd_q)
        TCS_CMD_CONFIG:
          if (idx_q == 2'h0)
            config_q <= shift_q;
        TCS_CMD_UPPER:
          if (idx_q == 2'h0)
            upper_trip_threshold_q[15:8] <= shift_q;
          else if (idx_q == 2'h1)
            upper_trip_threshold_q[7:0] <= shift_q;
        TCS_CMD_LOWER:
          if (idx_q == 2'h0)
            lower_trip_threshold_q[15:8] <= shift_q;
          else if (idx_q == 2'h1)
            lower_trip_threshold_q[7:0] <= shift_q;
        default: ;
      endcase
    end
  end

  // conversion control; a start in the done cycle wins
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      converting_q <= 1'b0;
      conv_start_q <= 1'b0;
    end
    else
    begin
      conv_start_q <= cmd_take && shift_q == TCS_CMD_START_CONV;
      if (cmd_take && shift_q == TCS_CMD_START_CONV)
        converting_q <= 1'b1;
      else if (soft_por)
        converting_q <= 1'b0;
      else if (cmd_take && shift_q == TCS_CMD_STOP_CONV && !single_conversion_select)
        converting_q <= 1'b0;
      else if (conv_done && single_conversion_select)
        converting_q <= 1'b0;
    end
  end
endmodule

// ==== verif/tcs_props.sv ====
// Purpose: timing checks on the two-wire link between both ends
// Assumes: master QUARTER of 4 ref_clk cycles, 16-cycle link period
// Notes: open-drain lines, an enable high pulls the line low
module tcs_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_o_m,
  input wire logic scl_oe_m,
  input wire logic sda_o_m,
  input wire logic sda_oe_m,
  input wire logic sda_o_s,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  a_open_drain: assert property (!scl_o_m && !sda_o_m && !sda_o_s)
    else $error("a line is driven high");
  a_reset_release: assert property ($rose(reset_n) |-> !scl_oe_m && !sda_oe_m && !sda_oe_s)
    else $error("line pulled at reset release");
  a_dev_scl_low: assert property ($changed(sda_oe_s) |-> !scl)
    else $error("device moved data while clock high");
  a_ack_held: assert property ($rose(sda_oe_s) |-> sda_oe_s [*8])
    else $error("device acknowledge too short");
  a_scl_high_len: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  // a start from idle opens with one short low quarter before the clock rises again
  a_scl_low_len: assert property ($fell(scl) && !$past(scl, 9) |-> !scl [*8])
    else $error("clock low phase too short");
  a_no_contention: assert property (sda_oe_s && scl |-> !sda_oe_m)
    else $error("both ends pull data while clock high");
  a_cond_hold: assert property ($changed(sda_oe_m) && scl |-> scl [*4])
    else $error("clock left high too briefly around start or stop");
  cover property ($rose(sda_oe_s));
  cover property ($fell(sda) && scl);
  cover property ($rose(sda) && scl);
endmodule

// ==== verif/testbench.sv ====
// Purpose: drives the master's request port, judges device registers and wire
// Assumes: both ends joined by one tcs_if, straps driven by the bench
// Notes: each request waits for done_q under a bounded count
module testbench import tcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset_n, req_valid, req_read, conv_done, req_ready_q, done_q, nack_q;
  logic converting_q, conv_start_q, scl_p, sda_p;
  logic [2:0] req_addr_sel, straps;
  logic [1:0] req_count;
  logic [3:0] bit_n;
  logic [7:0] sh;
  tcs_byte_t req_cmd, config_q, first_byte;
  logic [15:0] req_wdata, temperature_in, rdata_q, upper_q, lower_q;
  int num_errors, check_count, acks, starts, byte_n;
  tcs_if bus_if();
  tcs_master tcs_master_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus_if.master),
    .req_valid(req_valid), .req_read(req_read), .req_addr_sel(req_addr_sel),
    .req_cmd(req_cmd), .req_count(req_count), .req_wdata(req_wdata),
    .req_ready_q(req_ready_q), .done_q(done_q), .nack_q(nack_q), .rdata_q(rdata_q));
  tcs_device tcs_device_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus_if.device),
    .addr_select_hi(straps[2]), .addr_select_mid(straps[1]), .addr_select_lo(straps[0]),
    .temperature_in(temperature_in), .conv_done(conv_done), .config_q(config_q),
    .upper_trip_threshold_q(upper_q), .lower_trip_threshold_q(lower_q),
    .converting_q(converting_q), .conv_start_q(conv_start_q));
  tcs_props tcs_props_i (.ref_clk(ref_clk), .reset_n(reset_n), .scl_o_m(bus_if.scl_o_m),
    .scl_oe_m(bus_if.scl_oe_m), .sda_o_m(bus_if.sda_o_m), .sda_oe_m(bus_if.sda_oe_m),
    .sda_o_s(bus_if.sda_o_s), .sda_oe_s(bus_if.sda_oe_s), .scl(bus_if.scl), .sda(bus_if.sda));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // wire monitor: bytes after start, acknowledges seen in the ninth slot
  always @(posedge ref_clk)
  begin
    scl_p <= bus_if.scl;
    sda_p <= bus_if.sda;
    if (conv_start_q === 1'b1)
      starts <= starts + 1;
    if (scl_p && bus_if.scl && sda_p && !bus_if.sda)
    begin
      bit_n <= 4'h0;
      byte_n <= 0;
    end
    else if (!scl_p && bus_if.scl)
    begin
      if (bit_n == 4'h8)
      begin
        bit_n <= 4'h0;
        byte_n <= byte_n + 1;
        if (!bus_if.sda)
          acks <= acks + 1;
        if (byte_n == 0)
          first_byte <= sh;
      end
      else
      begin
        sh <= {sh[6:0], bus_if.sda};
        bit_n <= bit_n + 4'h1;
      end
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic rd, input logic [2:0] sel, input tcs_byte_t cmd,
    input logic [1:0] cnt, input logic [15:0] wd);
    int n;
    acks = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_addr_sel <= sel;
    req_cmd <= cmd;
    req_count <= cnt;
    req_wdata <= wd;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (n = 0; n < 4000 && done_q !== 1'b1; n++)
      @(posedge ref_clk);
    chk(16'(n < 4000), 16'h0001);
    @(posedge ref_clk);
  endtask
  task automatic pulse_done();
    @(posedge ref_clk);
    conv_done <= 1'b1;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_reset();
    chk(16'(config_q), 16'h0000);
    chk(upper_q, 16'h0000);
    chk(lower_q, 16'h0000);
    chk(16'(converting_q), 16'h0000);
    chk(16'(req_ready_q), 16'h0001);
  endtask
  task automatic t_config();
    xfer(1'b0, 3'h0, TCS_CMD_CONFIG, 2'h1, 16'h0200);
    chk(16'(first_byte), 16'h0090);
    chk(16'(acks), 16'h0003);
    chk(16'(config_q), 16'h0002);
    chk(16'(config_q[TCS_CFG_POL_BIT]), 16'h0001);
    chk(16'(config_q[TCS_CFG_ONESHOT_BIT]), 16'h0000);
    chk(16'(nack_q), 16'h0000);
  endtask
  task automatic t_thresh();
    xfer(1'b0, 3'h0, TCS_CMD_UPPER, 2'h2, 16'h2800);
    chk(16'(acks), 16'h0004);
    chk(upper_q, 16'h2800);
    xfer(1'b0, 3'h0, TCS_CMD_LOWER, 2'h2, 16'h0A00);
    chk(lower_q, 16'h0A00);
    chk(upper_q, 16'h2800);
  endtask
  task automatic t_conv();
    int s;
    s = starts;
    xfer(1'b0, 3'h0, TCS_CMD_START_CONV, 2'h0, 16'h0000);
    chk(16'(acks), 16'h0002);
    chk(16'(starts - s), 16'h0001);
    chk(16'(converting_q), 16'h0001);
    pulse_done();
    chk(16'(converting_q), 16'h0001);
    xfer(1'b0, 3'h0, TCS_CMD_STOP_CONV, 2'h0, 16'h0000);
    chk(16'(converting_q), 16'h0000);
  endtask
  task automatic t_oneshot();
    xfer(1'b0, 3'h0, TCS_CMD_CONFIG, 2'h1, 16'h0300);
    xfer(1'b0, 3'h0, TCS_CMD_START_CONV, 2'h0, 16'h0000);
    chk(16'(converting_q), 16'h0001);
    pulse_done();
    chk(16'(converting_q), 16'h0000);
    xfer(1'b0, 3'h0, TCS_CMD_CONFIG, 2'h1, 16'h0200);
  endtask
  task automatic t_foreign();
    xfer(1'b0, 3'h5, TCS_CMD_CONFIG, 2'h1, 16'h0500);
    chk(16'(nack_q), 16'h0001);
    chk(16'(acks), 16'h0000);
    chk(16'(config_q), 16'h0002);
    straps <= 3'h5;
    repeat (8) @(posedge ref_clk);
    xfer(1'b0, 3'h5, TCS_CMD_CONFIG, 2'h1, 16'h0300);
    chk(16'(nack_q), 16'h0000);
    chk(16'(config_q), 16'h0003);
    straps <= 3'h0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic t_read();
    xfer(1'b1, 3'h0, TCS_CMD_UPPER, 2'h2, 16'h0000);
    chk(rdata_q, 16'h2800);
    chk(16'(acks), 16'h0004);
    temperature_in <= 16'h1980;
    xfer(1'b1, 3'h0, TCS_CMD_READ_TEMP, 2'h2, 16'h0000);
    chk(rdata_q, 16'h1980);
    xfer(1'b1, 3'h0, TCS_CMD_CONFIG, 2'h1, 16'h0000);
    chk(16'(rdata_q[15:8]), 16'h0003);
    xfer(1'b0, 3'h0, TCS_CMD_SOFT_POR, 2'h0, 16'h0000);
    chk(16'(config_q), 16'h0000);
    chk(upper_q, 16'h0000);
    chk(lower_q, 16'h0000);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {reset_n, req_valid, req_read, conv_done} = 4'h0;
    {req_addr_sel, straps, req_count} = 8'h00;
    {req_cmd, req_wdata, temperature_in} = 40'h0;
    {num_errors, check_count, acks, starts, byte_n} = 160'h0;
    {bit_n, sh, first_byte} = 20'h0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_reset();
    t_config();
    t_thresh();
    t_conv();
    t_oneshot();
    t_foreign();
    t_read();
    report_and_stop();
  end
  initial
  begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule
